// ---- ewp_host.sv ----
// Serial link host model driving select, clock and data
`timescale 1ns/1ps
module ewp_host (
  // Clock
  input  wire logic clock_in,
  // Link pins
  output logic      sel_n_out,
  output logic      sclk_out,
  output logic      din_out,
  input  wire logic dout_in
);
  initial begin
    sel_n_out = 1'b1;
    sclk_out  = 1'b0;
    din_out   = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic sel();
    wt(1);
    sel_n_out = 1'b0;
    wt(4);
  endtask
  // Deselect after the last rise, released data toggles
  task automatic desel();
    wt(2);
    sel_n_out = 1'b1;
    din_out   = ~din_out;
    wt(8);
  endtask
  // One bit, MSB order kept by caller, data in sampled by the slave on the rising clock
  task automatic bx(input logic b, output logic r);
    din_out  = b;
    wt(4);
    sclk_out = 1'b1;
    wt(4);
    r        = dout_in;
    sclk_out = 1'b0;
  endtask
endmodule

// ---- ewp_pkg.sv ----
// Constants shared by the status and write-protection logic
package ewp_pkg;

  // ****************************************
  // Command opcodes, sent MSB first
  // ****************************************
  localparam logic [7:0] LATCH_SET_CMD    = 8'h06;
  localparam logic [7:0] LATCH_CLEAR_CMD  = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;

  // ****************************************
  // Status byte field positions
  // ****************************************
  localparam int unsigned STATUS_LOCK_POS  = 7;
  localparam int unsigned PROTECT_HI_POS   = 3;
  localparam int unsigned PROTECT_LO_POS   = 2;
  localparam int unsigned WRITE_LATCH_POS  = 1;
  localparam int unsigned WRITE_BUSY_POS   = 0;

  // ****************************************
  // Nonvolatile delivery state and volatile reset values
  // ****************************************
  localparam logic       STATUS_LOCK_INIT = 1'b0;
  localparam logic [1:0] PROTECT_INIT     = 2'h0;
  localparam logic       WRITE_LATCH_RST  = 1'b0;
  localparam logic       WRITE_BUSY_RST   = 1'b0;

  // ****************************************
  // Array geometry and protected region bases
  // ****************************************
  localparam int unsigned ADDR_W        = 18;
  localparam logic [17:0] QUARTER_BASE  = 18'h30000;
  localparam logic [17:0] HALF_BASE     = 18'h20000;
  localparam logic [17:0] WHOLE_BASE    = 18'h00000;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLOCK_MHZ          = 25;
  localparam int unsigned SYNC_STAGES        = 2;
  localparam int unsigned SELF_TIMED_WRITE_TIME_US = 10000;

  // ****************************************
  // Protocol states, one-hot
  // ****************************************
  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_CMD    = 5'h02,
    ST_STATUS_READ_CMD   = 5'h04,
    ST_WDATA  = 5'h08,
    ST_IGNORE = 5'h10
  } ewp_state_t;

endpackage

// ---- ewp_status_protect.sv ----
// Status register, write latch and protection logic of a serial memory slave
`timescale 1ns/1ps
module ewp_status_protect
  import ewp_pkg::*;
#(
  parameter int unsigned WRITE_TIME_US = SELF_TIMED_WRITE_TIME_US,
  parameter int unsigned CLK_MHZ       = CLOCK_MHZ
)
(
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  // Serial link pins
  input  wire logic              sel_n_in,
  input  wire logic              sclk_in,
  input  wire logic              din_in,
  output logic                   dout_out,
  output logic                   dout_oe_out,
  // Write protect pin
  input  wire logic              write_prot_n_in,
  // Array write requests from the array logic
  input  wire logic              array_wr_req_in,
  input  wire logic [ADDR_W-1:0] array_wr_addr_in,
  output logic                   array_wr_accept_out,
  output logic                   array_wr_reject_out,
  // Observed state
  output logic [7:0]             protection_status_out,
  output logic                   hardware_lock_mode_out,
  output logic                   software_lock_mode_out
);

  // ****************************************
  // Timing and elaboration check
  // ****************************************
  localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned TIMER_W      = $clog2(WRITE_CYCLES + 1);

  if (WRITE_CYCLES < 1) begin : g_bad_time
    $error("Self-timed write must last at least one cycle");
  end

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic addr_protected(input logic [1:0] bp, input logic [ADDR_W-1:0] addr);
    logic res;
    res = 1'b0;
    case (bp)
      2'h1:    res = (addr >= QUARTER_BASE);
      2'h2:    res = (addr >= HALF_BASE);
      2'h3:    res = (addr >= WHOLE_BASE);
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  function automatic logic [7:0] status_byte(input logic lock, input logic [1:0] bp,
                                             input logic latch, input logic busy);
    logic [7:0] b;
    b = 8'h00;
    b[STATUS_LOCK_POS] = lock;
    b[PROTECT_HI_POS]  = bp[1];
    b[PROTECT_LO_POS]  = bp[0];
    b[WRITE_LATCH_POS] = latch;
    b[WRITE_BUSY_POS]  = busy;
    return b;
  endfunction

  // ****************************************
  // Synchronised pins
  // ****************************************
  logic sel_n_s;
  logic sel_rise;
  logic sel_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic din_s;
  logic wp_n_s;

  ewp_sync u_sync (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .sel_n_in      (sel_n_in),
    .sclk_in       (sclk_in),
    .din_in        (din_in),
    .wp_n_in       (write_prot_n_in),
    .sel_n_out     (sel_n_s),
    .sel_rise_out  (sel_rise),
    .sel_fall_out  (sel_fall),
    .sclk_rise_out (sclk_rise),
    .sclk_fall_out (sclk_fall),
    .din_out       (din_s),
    .wp_n_out      (wp_n_s)
  );

  // ****************************************
  // Core state declarations
  // ****************************************
  logic               latch_reg;
  logic               latch_next;
  logic               busy_reg;
  logic               busy_next;
  logic [TIMER_W-1:0] timer_reg;
  logic [TIMER_W-1:0] timer_next;
  logic               sw_cycle_reg;
  logic               sw_cycle_next;
  logic [2:0]         nv_new_reg;
  logic [2:0]         nv_new_next;
  logic               acc_reg;
  logic               acc_next;
  logic               rej_reg;
  logic               rej_next;
  logic               lock_reg = STATUS_LOCK_INIT;
  logic               lock_next;
  logic [1:0]         bp_reg = PROTECT_INIT;
  logic [1:0]         bp_next;
  logic               hw_lock;
  logic [7:0]         status_now;

  assign hw_lock    = lock_reg & ~wp_n_s;
  assign status_now = status_byte(lock_reg, bp_reg, latch_reg, busy_reg);

  // ****************************************
  // Protocol state declarations
  // ****************************************
  ewp_state_t state_reg;
  ewp_state_t state_next;
  logic [2:0] bit_cnt_reg;
  logic [2:0] bit_cnt_next;
  logic [7:0] in_sr_reg;
  logic [7:0] in_sr_next;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic       full_reg;
  logic       full_next;
  logic       bad_reg;
  logic       bad_next;
  logic       pend_set_reg;
  logic       pend_set_next;
  logic       pend_clr_reg;
  logic       pend_clr_next;
  logic [2:0] out_cnt_reg;
  logic [2:0] out_cnt_next;
  logic [7:0] snap_reg;
  logic [7:0] snap_next;
  logic       dout_reg;
  logic       dout_next;
  logic       oe_reg;
  logic       oe_next;
  logic       latch_set_cmd_go;
  logic       latch_clear_cmd_go;
  logic       status_write_cmd_go;
  logic [7:0] byte_in;

  // ****************************************
  // Serial protocol next state
  // ****************************************
  always_comb begin
    state_next    = state_reg;
    bit_cnt_next  = bit_cnt_reg;
    in_sr_next    = in_sr_reg;
    data_next     = data_reg;
    full_next     = full_reg;
    bad_next      = bad_reg;
    pend_set_next = pend_set_reg;
    pend_clr_next = pend_clr_reg;
    out_cnt_next  = out_cnt_reg;
    snap_next     = snap_reg;
    dout_next     = dout_reg;
    oe_next       = oe_reg;
    latch_set_cmd_go       = 1'b0;
    latch_clear_cmd_go       = 1'b0;
    status_write_cmd_go       = 1'b0;
    byte_in       = {in_sr_reg[6:0], din_s};
    if (sel_rise) begin
      latch_set_cmd_go   = (state_reg == ST_IGNORE) && pend_set_reg;
      latch_clear_cmd_go   = (state_reg == ST_IGNORE) && pend_clr_reg;
      status_write_cmd_go   = (state_reg == ST_WDATA) && full_reg && !bad_reg;
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else if (sel_fall) begin
      state_next    = ST_CMD;
      bit_cnt_next  = 3'h0;
      full_next     = 1'b0;
      bad_next      = 1'b0;
      pend_set_next = 1'b0;
      pend_clr_next = 1'b0;
      out_cnt_next  = 3'h0;
    end else if (!sel_n_s) begin
      case (state_reg)
        ST_CMD: begin
          if (sclk_rise) begin
            in_sr_next   = byte_in;
            bit_cnt_next = bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
              case (byte_in)
                LATCH_SET_CMD: begin
                  pend_set_next = 1'b1;
                  state_next    = ST_IGNORE;
                end
                LATCH_CLEAR_CMD: begin
                  pend_clr_next = 1'b1;
                  state_next    = ST_IGNORE;
                end
                STATUS_READ_CMD: begin
                  state_next = ST_STATUS_READ_CMD;
                end
                STATUS_WRITE_CMD: begin
                  state_next = ST_WDATA;
                end
                default: begin
                  state_next = ST_IGNORE;
                end
              endcase
            end
          end
        end
        ST_STATUS_READ_CMD: begin
          if (sclk_fall) begin
            oe_next      = 1'b1;
            out_cnt_next = out_cnt_reg + 3'h1;
            if (out_cnt_reg == 3'h0) begin
              snap_next = status_now;
              dout_next = status_now[7];
            end else begin
              dout_next = snap_reg[3'h7 - out_cnt_reg];
            end
          end
        end
        ST_WDATA: begin
          if (sclk_rise) begin
            if (full_reg) begin
              bad_next = 1'b1;
            end else begin
              in_sr_next   = byte_in;
              bit_cnt_next = bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                data_next = byte_in;
                full_next = 1'b1;
              end
            end
          end
        end
        ST_IGNORE: begin
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 3'h0;
      in_sr_reg    <= 8'h00;
      data_reg     <= 8'h00;
      full_reg     <= 1'b0;
      bad_reg      <= 1'b0;
      pend_set_reg <= 1'b0;
      pend_clr_reg <= 1'b0;
      out_cnt_reg  <= 3'h0;
      snap_reg     <= 8'h00;
      dout_reg     <= 1'b0;
      oe_reg       <= 1'b0;
    end else begin
      state_reg    <= state_next;
      bit_cnt_reg  <= bit_cnt_next;
      in_sr_reg    <= in_sr_next;
      data_reg     <= data_next;
      full_reg     <= full_next;
      bad_reg      <= bad_next;
      pend_set_reg <= pend_set_next;
      pend_clr_reg <= pend_clr_next;
      out_cnt_reg  <= out_cnt_next;
      snap_reg     <= snap_next;
      dout_reg     <= dout_next;
      oe_reg       <= oe_next;
    end
  end

  // ****************************************
  // Latch, busy cycle and nonvolatile bits next state
  // ****************************************
  logic status_write_cmd_ok;
  logic arr_ok;

  always_comb begin
    latch_next    = latch_reg;
    busy_next     = busy_reg;
    timer_next    = timer_reg;
    sw_cycle_next = sw_cycle_reg;
    nv_new_next   = nv_new_reg;
    lock_next     = lock_reg;
    bp_next       = bp_reg;
    acc_next      = 1'b0;
    rej_next      = 1'b0;
    status_write_cmd_ok = status_write_cmd_go && latch_reg && !busy_reg && !hw_lock;
    arr_ok  = array_wr_req_in && latch_reg && !busy_reg && !status_write_cmd_go
              && !addr_protected(bp_reg, array_wr_addr_in);
    if (busy_reg) begin
      if (timer_reg == '0) begin
        busy_next  = 1'b0;
        latch_next = 1'b0;
        if (sw_cycle_reg) begin
          lock_next = nv_new_reg[2];
          bp_next   = nv_new_reg[1:0];
        end
      end else begin
        timer_next = timer_reg - TIMER_W'(1);
      end
    end
    if (status_write_cmd_ok) begin
      busy_next     = 1'b1;
      timer_next    = TIMER_W'(WRITE_CYCLES - 1);
      sw_cycle_next = 1'b1;
      nv_new_next   = {data_reg[STATUS_LOCK_POS], data_reg[PROTECT_HI_POS],
                       data_reg[PROTECT_LO_POS]};
    end else if (arr_ok) begin
      busy_next     = 1'b1;
      timer_next    = TIMER_W'(WRITE_CYCLES - 1);
      sw_cycle_next = 1'b0;
    end
    if (array_wr_req_in) begin
      acc_next = arr_ok;
      rej_next = !arr_ok;
    end
    if (latch_set_cmd_go) begin
      latch_next = 1'b1;
    end else if (latch_clear_cmd_go) begin
      latch_next = 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      latch_reg    <= WRITE_LATCH_RST;
      busy_reg     <= WRITE_BUSY_RST;
      timer_reg    <= '0;
      sw_cycle_reg <= 1'b0;
      nv_new_reg   <= 3'h0;
      acc_reg      <= 1'b0;
      rej_reg      <= 1'b0;
    end else begin
      latch_reg    <= latch_next;
      busy_reg     <= busy_next;
      timer_reg    <= timer_next;
      sw_cycle_reg <= sw_cycle_next;
      nv_new_reg   <= nv_new_next;
      acc_reg      <= acc_next;
      rej_reg      <= rej_next;
    end
  end

  // Nonvolatile bits survive reset
  always_ff @(posedge clock_in) begin
    lock_reg <= lock_next;
    bp_reg   <= bp_next;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign dout_out               = dout_reg;
  assign dout_oe_out            = oe_reg;
  assign array_wr_accept_out    = acc_reg;
  assign array_wr_reject_out    = rej_reg;
  assign protection_status_out  = status_now;
  assign hardware_lock_mode_out = hw_lock;
  assign software_lock_mode_out = ~hw_lock;

endmodule

// ---- ewp_status_protect_props.sv ----
// Checker for the status and write-protection block
`timescale 1ns/1ps
module ewp_status_protect_props
  import ewp_pkg::*;
#(
  parameter int unsigned WRITE_TIME_US = SELF_TIMED_WRITE_TIME_US,
  parameter int unsigned CLK_MHZ       = CLOCK_MHZ
)
(
  // Clock and reset
  input wire logic              clock_in,
  input wire logic              rst_in,
  // Link and pin
  input wire logic              sel_n_in,
  input wire logic              sclk_in,
  input wire logic              din_in,
  input wire logic              dout_out,
  input wire logic              dout_oe_out,
  input wire logic              write_prot_n_in,
  // Array port
  input wire logic              array_wr_req_in,
  input wire logic [ADDR_W-1:0] array_wr_addr_in,
  input wire logic              array_wr_accept_out,
  input wire logic              array_wr_reject_out,
  // State
  input wire logic [7:0]        protection_status_out,
  input wire logic              hardware_lock_mode_out,
  input wire logic              software_lock_mode_out
);
  localparam int unsigned CYCLES = WRITE_TIME_US * CLK_MHZ;
  logic        busy;
  logic        latch;
  int unsigned cnt_reg;
  int unsigned cnt_next;
  assign busy  = protection_status_out[0];
  assign latch = protection_status_out[1];
  always_comb begin
    cnt_next = busy ? cnt_reg + 1 : 0;
  end
  always_ff @(posedge clock_in) begin
    cnt_reg <= rst_in ? 0 : cnt_next;
  end
  function automatic logic prot(input logic [1:0] bp, input logic [17:0] a);
    case (bp)
      2'b01:   return a >= QUARTER_BASE;
      2'b10:   return a >= HALF_BASE;
      2'b11:   return 1'b1;
      default: return 1'b0;
    endcase
  endfunction
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence desel_8;
    sel_n_in [*8];
  endsequence
  zero_bits_a : assert property (protection_status_out[6:4] == 3'h0)
    else $error("status bits 6..4 not zero");
  reply_cause_a : assert property ((array_wr_accept_out || array_wr_reject_out) |-> $past(array_wr_req_in))
    else $error("array reply without request");
  accept_busy_a : assert property (array_wr_accept_out |-> busy)
    else $error("accepted write not busy");
  latch_needed_a : assert property (array_wr_req_in && !latch |=> array_wr_reject_out)
    else $error("write accepted with latch clear");
  region_reject_a : assert property (array_wr_req_in && prot(protection_status_out[3:2], array_wr_addr_in)
    |=> array_wr_reject_out)
    else $error("protected address not rejected");
  busy_len_a : assert property ($fell(busy) |-> cnt_reg == CYCLES)
    else $error("busy length wrong");
  latch_end_a : assert property ($fell(busy) |-> !latch)
    else $error("latch kept after write cycle");
  nv_change_a : assert property (!$stable(protection_status_out[7:2]) |-> $fell(busy))
    else $error("nonvolatile bits changed outside cycle end");
  lock_mode_a : assert property (software_lock_mode_out == !hardware_lock_mode_out
    && (!hardware_lock_mode_out || protection_status_out[7]))
    else $error("lock modes inconsistent");
  oe_idle_a : assert property (desel_8 |-> !dout_oe_out)
    else $error("output enabled while deselected");
  latch_rise_a : assert property ($rose(latch) |-> sel_n_in && $past(sel_n_in, 2))
    else $error("latch set before deselect");
endmodule
bind ewp_status_protect ewp_status_protect_props #(.WRITE_TIME_US(WRITE_TIME_US), .CLK_MHZ(CLK_MHZ)) u_props (
  .clock_in(clock_in), .rst_in(rst_in), .sel_n_in(sel_n_in), .sclk_in(sclk_in), .din_in(din_in),
  .dout_out(dout_out), .dout_oe_out(dout_oe_out), .write_prot_n_in(write_prot_n_in),
  .array_wr_req_in(array_wr_req_in), .array_wr_addr_in(array_wr_addr_in),
  .array_wr_accept_out(array_wr_accept_out), .array_wr_reject_out(array_wr_reject_out),
  .protection_status_out(protection_status_out), .hardware_lock_mode_out(hardware_lock_mode_out),
  .software_lock_mode_out(software_lock_mode_out));

// ---- ewp_sync.sv ----
// Pin synchronisers and edge detection for the serial link
`timescale 1ns/1ps
module ewp_sync
  import ewp_pkg::*;
(
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_in,
  // Raw pins
  input  wire logic sel_n_in,
  input  wire logic sclk_in,
  input  wire logic din_in,
  input  wire logic wp_n_in,
  // Synchronised levels and edges
  output logic      sel_n_out,
  output logic      sel_rise_out,
  output logic      sel_fall_out,
  output logic      sclk_rise_out,
  output logic      sclk_fall_out,
  output logic      din_out,
  output logic      wp_n_out
);

  // ****************************************
  // Two-stage synchronisers plus history stage
  // ****************************************
  logic [3:0] meta_reg;
  logic [3:0] meta_next;
  logic [3:0] sync_reg;
  logic [3:0] sync_next;
  logic [1:0] hist_reg;
  logic [1:0] hist_next;

  always_comb begin
    meta_next = {wp_n_in, din_in, sclk_in, sel_n_in};
    sync_next = meta_reg;
    hist_next = sync_reg[1:0];
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      meta_reg <= 4'h9;
      sync_reg <= 4'h9;
      hist_reg <= 2'h1;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      hist_reg <= hist_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign sel_n_out     = sync_reg[0];
  assign sel_rise_out  = sync_reg[0] & ~hist_reg[0];
  assign sel_fall_out  = ~sync_reg[0] & hist_reg[0];
  assign sclk_rise_out = sync_reg[1] & ~hist_reg[1];
  assign sclk_fall_out = ~sync_reg[1] & hist_reg[1];
  assign din_out       = sync_reg[2];
  assign wp_n_out      = sync_reg[3];

endmodule

// ---- tb.sv ----
// Self-checking testbench for the status and write-protection block
`timescale 1ns/1ps
module tb;
  import ewp_pkg::*;
  logic        clock_in = 1'b0;
  logic        rst_in   = 1'b1;
  logic        wp_n     = 1'b1;
  logic        req;
  logic [17:0] addr;
  logic        sel_n, sclk, din, dout, oe, acc, rej, hw, sw;
  logic [7:0]  st;
  int          failures   = 0;
  int          num_checks = 0;
  always #20 clock_in = ~clock_in;
  // A disabled output shows the inverse of its last bit, so a late enable is caught
  ewp_host h (.clock_in(clock_in), .sel_n_out(sel_n), .sclk_out(sclk), .din_out(din),
              .dout_in(oe ? dout : ~dout));
  ewp_status_protect #(.WRITE_TIME_US(10)) DUT (
    .clock_in(clock_in), .rst_in(rst_in), .sel_n_in(sel_n), .sclk_in(sclk), .din_in(din),
    .dout_out(dout), .dout_oe_out(oe), .write_prot_n_in(wp_n), .array_wr_req_in(req),
    .array_wr_addr_in(addr), .array_wr_accept_out(acc), .array_wr_reject_out(rej),
    .protection_status_out(st), .hardware_lock_mode_out(hw), .software_lock_mode_out(sw));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic xb(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) h.bx(t[i], r[i]);
  endtask
  task automatic cmd(input logic [7:0] op);
    logic [7:0] r;
    h.sel();
    xb(op, r);
    h.desel();
  endtask
  task automatic wsr(input logic [7:0] d);
    logic [7:0] r;
    h.sel();
    xb(STATUS_WRITE_CMD, r);
    xb(d, r);
    h.desel();
  endtask
  task automatic rds(output logic [7:0] s);
    logic [7:0] r;
    h.sel();
    xb(STATUS_READ_CMD, r);
    xb(8'h00, s);
    h.desel();
  endtask
  task automatic idle();
    logic [7:0] s;
    int         n;
    s = 8'hFF;
    for (n = 0; n < 20 && s[0] !== 1'b0; n++) rds(s);
    chk({7'h00, s[0]}, 8'h00);
    h.wt(2);
  endtask
  task automatic arr(input logic [17:0] a, output logic [1:0] r);
    @(negedge clock_in);
    req  = 1'b1;
    addr = a;
    @(negedge clock_in);
    req  = 1'b0;
    r    = {acc, rej};
    @(negedge clock_in);
    r    = r | {acc, rej};
  endtask
  task automatic t_latch();
    logic [7:0] s;
    chk(st, 8'h00);
    cmd(LATCH_SET_CMD);
    rds(s);
    chk(s, 8'h02);
    h.sel();
    xb(LATCH_CLEAR_CMD, s);
    xb(LATCH_SET_CMD, s);
    chk(st, 8'h02);
    h.desel();
    chk(st, 8'h00);
    h.sel();
    xb(LATCH_SET_CMD, s);
    xb(LATCH_CLEAR_CMD, s);
    chk(st, 8'h00);
    h.desel();
    chk(st, 8'h02);
    cmd(LATCH_CLEAR_CMD);
    h.sel();
    xb(8'hA5, s);
    xb(LATCH_SET_CMD, s);
    h.desel();
    chk(st, 8'h00);
    $display("test latch done");
  endtask
  task automatic t_swrite();
    logic [7:0] s, s2;
    logic       b;
    wsr(8'h8C);
    chk(st, 8'h00);
    cmd(LATCH_SET_CMD);
    wsr(8'hFF);
    rds(s);
    chk(s, 8'h03);
    idle();
    chk(st, 8'h8C);
    cmd(LATCH_SET_CMD);
    h.sel();
    xb(STATUS_WRITE_CMD, s);
    xb(8'h00, s);
    h.bx(1'b0, b);
    h.desel();
    h.wt(4);
    chk(st, 8'h8E);
    wsr(8'h00);
    idle();
    chk(st, 8'h00);
    h.sel();
    xb(STATUS_READ_CMD, s);
    xb(8'h00, s);
    xb(8'h00, s2);
    chk({7'h00, oe}, 8'h01);
    h.desel();
    chk({7'h00, oe}, 8'h00);
    chk(s2, 8'h00);
    $display("test status write done");
  endtask
  task automatic t_array();
    logic [17:0] lo [4] = '{18'h2FFFF, 18'h2FFFF, 18'h1FFFF, 18'h3FFFF};
    logic [17:0] hi [4] = '{18'h3FFFF, QUARTER_BASE, HALF_BASE, WHOLE_BASE};
    logic [1:0]  r;
    arr(18'h00000, r);
    chk({6'h00, r}, 8'h01);
    for (int bp = 0; bp < 4; bp++) begin
      cmd(LATCH_SET_CMD);
      wsr({4'h0, bp[1:0], 2'b00});
      idle();
      chk(st, {4'h0, bp[1:0], 2'b00});
      cmd(LATCH_SET_CMD);
      arr(lo[bp], r);
      chk({6'h00, r}, (bp != 3) ? 8'h02 : 8'h01);
      idle();
      cmd(LATCH_SET_CMD);
      arr(hi[bp], r);
      chk({6'h00, r}, (bp == 0) ? 8'h02 : 8'h01);
      idle();
    end
    cmd(LATCH_SET_CMD);
    wsr(8'h00);
    idle();
    chk(st, 8'h00);
    $display("test array done");
  endtask
  task automatic t_lock();
    @(negedge clock_in) wp_n = 1'b0;
    cmd(LATCH_SET_CMD);
    wsr(8'h80);
    idle();
    chk(st, 8'h80);
    chk({6'h00, hw, sw}, 8'h02);
    cmd(LATCH_SET_CMD);
    wsr(8'h00);
    idle();
    chk(st, 8'h82);
    @(negedge clock_in) wp_n = 1'b1;
    h.wt(4);
    chk({6'h00, hw, sw}, 8'h01);
    wsr(8'h80);
    idle();
    @(negedge clock_in) wp_n = 1'b0;
    h.wt(4);
    chk({6'h00, hw, sw}, 8'h02);
    @(negedge clock_in) wp_n = 1'b1;
    cmd(LATCH_SET_CMD);
    wsr(8'h00);
    idle();
    chk(st, 8'h00);
    $display("test lock done");
  endtask
  task automatic results();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    failures++;
    results();
  end
  initial begin
    req  = 1'b0;
    addr = 18'h00000;
    repeat (10) @(negedge clock_in);
    rst_in = 1'b0;
    h.wt(4);
    t_latch();
    t_swrite();
    t_array();
    t_lock();
    results();
  end
endmodule
